// ===== core/sfs_pkg.sv
package sfs_pkg;
    // Opcodes
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_STATUS_RD_LO = 8'h05;
    localparam logic [7:0] CMD_STATUS_RD_HI = 8'h35;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
    localparam logic [7:0] CMD_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] CMD_BLOCK32_WIPE = 8'h52;
    localparam logic [7:0] CMD_BLOCK64_WIPE = 8'hD8;
    localparam logic [7:0] CMD_CHIP_WIPE_A = 8'hC7;
    localparam logic [7:0] CMD_CHIP_WIPE_B = 8'h60;
    localparam logic [7:0] CMD_RESET_ARM = 8'h66;
    localparam logic [7:0] CMD_RESET_GO = 8'h99;
    localparam logic [7:0] CMD_SUSPEND = 8'h75;
    localparam logic [7:0] CMD_RESUME = 8'h7A;
    localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    localparam logic [7:0] CMD_HIGH_PERF = 8'hA3;
    // Bit positions of status_word
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 6;
    localparam int BIT_SPS_LO = 7;
    localparam int BIT_SPS_HI = 8;
    localparam int BIT_QUAD = 9;
    localparam int BIT_LOCK = 10;
    localparam int BIT_PERF = 13;
    localparam int BIT_INV = 14;
    localparam int BIT_SUSP = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_WRITE_MASK = 16'h47FC;
    // Status-protect select modes
    localparam logic [1:0] SPS_SOFT = 2'h0;
    localparam logic [1:0] SPS_HW = 2'h1;
    // Frame lengths in whole bytes
    localparam logic [7:0] LEN_OPCODE = 8'h01;
    localparam logic [7:0] LEN_SR_HALF = 8'h02;
    localparam logic [7:0] LEN_SR_FULL = 8'h03;
    localparam logic [7:0] LEN_ADDR_FRAME = 8'h04;
    localparam logic [7:0] LEN_PAGE_MIN = 8'h05;
    // Data path buffer
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [2:0] {
        OPK_NONE, OPK_STATUS, OPK_PAGE, OPK_SECTOR, OPK_BLOCK32, OPK_BLOCK64, OPK_CHIP
    } sfs_op_t;
endpackage : sfs_pkg

// ===== core/sfs_flash_status.sv
`timescale 1ns/1ns

module sfs_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input logic clk,
    input logic srst,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // Extra pointer bit tells full from empty
    assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q[AW-1:0]];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : sfs_byte_fifo

module sfs_flash_status (
    input logic clk,
    input logic srst,
    input logic cs_n,
    input logic sclk,
    input logic si,
    output logic so,
    output logic so_oe,
    input logic wp_n,
    output logic quad_mode,
    output logic [15:0] status_word,
    output logic op_start,
    output sfs_pkg::sfs_op_t op_kind,
    output logic [23:0] op_addr,
    output logic op_abort,
    input logic op_done,
    output logic [7:0] prog_data,
    output logic prog_valid,
    input logic prog_ready,
    output logic prog_overflow
);
    import sfs_pkg::*;

    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    logic [2:0] cs_sh_q;
    logic [2:0] sclk_sh_q;
    logic [1:0] si_sh_q;
    logic [1:0] wp_sh_q;
    logic cs_s;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;

    // Two stages before any use; third stage only feeds edge detection
    always_ff @(posedge clk) begin
        if (srst) begin
            cs_sh_q <= 3'h7;
            sclk_sh_q <= 3'h0;
            si_sh_q <= 2'h0;
            wp_sh_q <= 2'h3;
        end else begin
            cs_sh_q <= {cs_sh_q[1:0], cs_n};
            sclk_sh_q <= {sclk_sh_q[1:0], sclk};
            si_sh_q <= {si_sh_q[0], si};
            wp_sh_q <= {wp_sh_q[0], wp_n};
        end
    end
    assign cs_s = cs_sh_q[1];
    assign sclk_rise = !cs_s && sclk_sh_q[1] && !sclk_sh_q[2];
    assign sclk_fall = !cs_s && !sclk_sh_q[1] && sclk_sh_q[2];
    assign frame_start = !cs_s && cs_sh_q[2];
    assign frame_end = cs_s && !cs_sh_q[2];

    // ************************************************************
    // Frame receiver
    // ************************************************************
    logic [6:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] byte_cnt_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [15:0] sr_in_q;
    logic byte_done;
    logic [7:0] rx_byte;

    assign byte_done = sclk_rise && (bit_cnt_q == 3'h7);
    assign rx_byte = {shift_q, si_sh_q[1]};

    // MSB first, one bit per rising serial edge from the frame's start
    always_ff @(posedge clk) begin
        if (srst || frame_start) begin
            shift_q <= 7'h00;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 8'h00;
        end else if (sclk_rise) begin
            shift_q <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done && byte_cnt_q != 8'hFF) begin
                byte_cnt_q <= byte_cnt_q + 8'h01;
            end
        end
    end

    // Opcode, address and status payload capture
    always_ff @(posedge clk) begin
        if (srst) begin
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            sr_in_q <= 16'h0000;
        end else if (byte_done) begin
            if (byte_cnt_q == 8'h00) begin
                opcode_q <= rx_byte;
            end
            if (byte_cnt_q >= 8'h01 && byte_cnt_q <= 8'h03) begin
                addr_q <= {addr_q[15:0], rx_byte};
            end
            if (byte_cnt_q == 8'h01) begin
                sr_in_q[7:0] <= rx_byte;
            end
            if (byte_cnt_q == 8'h02) begin
                sr_in_q[15:8] <= rx_byte;
            end
        end
    end

    // ************************************************************
    // Status bits and protection decode
    // ************************************************************
    logic [15:0] nv_q;
    logic busy_q;
    logic latch_q;
    logic perf_q;
    logic susp_q;
    logic sleep_q;
    logic reset_armed_q;

    // Shielded-region test on the 4 KB page index of a 512 KB array
    function automatic logic page_shielded(input logic [4:0] bp, input logic inv, input logic [6:0] pg);
        logic [7:0] units;
        logic hit;
        units = 8'h00;
        if (bp[2:0] == 3'h0) begin
            units = 8'h00;
        end else if (!bp[4]) begin
            units = bp[2] ? 8'h80 : (bp[1:0] == 2'h1 ? 8'h10 : (bp[1:0] == 2'h2 ? 8'h20 : 8'h40));
        end else if (bp[2:0] == 3'h7) begin
            units = 8'h80;
        end else begin
            units = bp[2] ? 8'h08 : (bp[1:0] == 2'h1 ? 8'h01 : (bp[1:0] == 2'h2 ? 8'h02 : 8'h04));
        end
        hit = bp[3] ? ({1'b0, pg} < units) : ({1'b0, pg} >= (8'h80 - units));
        return hit ^ inv;
    endfunction : page_shielded

    logic [1:0] sps;
    logic wp_eff_n;
    logic addr_shielded;
    logic chip_ok;
    logic sr_write_ok;
    logic may_modify;

    assign sps = {nv_q[BIT_SPS_HI], nv_q[BIT_SPS_LO]};
    assign wp_eff_n = nv_q[BIT_QUAD] | wp_sh_q[1];
    assign quad_mode = nv_q[BIT_QUAD];
    assign addr_shielded = page_shielded(nv_q[BIT_BP_HI:BIT_BP_LO], nv_q[BIT_INV], addr_q[18:12]);
    assign chip_ok = (nv_q[4:2] == 3'h0 && !nv_q[BIT_INV]) || (nv_q[4:2] == 3'h7 && nv_q[BIT_INV]);
    assign may_modify = latch_q && !busy_q && !sleep_q;
    // Lock-down and one-time modes never pass; hardware mode needs the pin high unless quad mode is set
    assign sr_write_ok = may_modify && (sps == SPS_SOFT || (sps == SPS_HW && wp_eff_n));

    assign status_word = {susp_q, nv_q[BIT_INV], perf_q, 2'h0, nv_q[10:2], latch_q, busy_q};

    // ************************************************************
    // Frame-end command decode
    // ************************************************************
    logic aligned;
    logic go_status;
    logic go_page;
    logic go_sector;
    logic go_b32;
    logic go_b64;
    logic go_chip;
    logic go_any_op;
    logic sleep_gate;

    assign aligned = frame_end && bit_cnt_q == 3'h0;
    assign sleep_gate = !sleep_q;
    assign go_status = aligned && sleep_gate && opcode_q == CMD_STATUS_WRITE
        && (byte_cnt_q == LEN_SR_HALF || byte_cnt_q == LEN_SR_FULL) && sr_write_ok;
    assign go_page = aligned && opcode_q == CMD_PAGE_WRITE && byte_cnt_q >= LEN_PAGE_MIN
        && may_modify && !addr_shielded;
    assign go_sector = aligned && opcode_q == CMD_SECTOR_WIPE && byte_cnt_q == LEN_ADDR_FRAME
        && may_modify && !addr_shielded;
    assign go_b32 = aligned && opcode_q == CMD_BLOCK32_WIPE && byte_cnt_q == LEN_ADDR_FRAME
        && may_modify && !addr_shielded;
    assign go_b64 = aligned && opcode_q == CMD_BLOCK64_WIPE && byte_cnt_q == LEN_ADDR_FRAME
        && may_modify && !addr_shielded;
    assign go_chip = aligned && (opcode_q == CMD_CHIP_WIPE_A || opcode_q == CMD_CHIP_WIPE_B)
        && byte_cnt_q == LEN_OPCODE && may_modify && chip_ok;
    assign go_any_op = go_status | go_page | go_sector | go_b32 | go_b64 | go_chip;

    logic short_cmd;
    logic reset_go;
    assign short_cmd = aligned && byte_cnt_q == LEN_OPCODE;
    assign reset_go = short_cmd && opcode_q == CMD_RESET_GO && reset_armed_q;

    // Stored bits: only the writable mask moves; lock bit can only rise
    always_ff @(posedge clk) begin
        if (srst) begin
            nv_q <= STATUS_RESET;
        end else if (go_status) begin
            nv_q <= (nv_q & ~STATUS_WRITE_MASK) & 16'hFFFF; // cleared below per byte
            if (byte_cnt_q == LEN_SR_HALF) begin
                nv_q <= {nv_q[15:8], (sr_in_q[7:0] & STATUS_WRITE_MASK[7:0])};
            end else begin
                nv_q <= sr_in_q & STATUS_WRITE_MASK;
            end
            nv_q[BIT_LOCK] <= nv_q[BIT_LOCK] | (byte_cnt_q == LEN_SR_FULL && sr_in_q[BIT_LOCK]);
        end
    end

    // Write latch: rejected frames leave it untouched
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_q <= 1'b0;
        end else if (reset_go || go_any_op || (short_cmd && sleep_gate && opcode_q == CMD_LATCH_CLR)) begin
            latch_q <= 1'b0;
        end else if (short_cmd && sleep_gate && opcode_q == CMD_LATCH_SET) begin
            latch_q <= 1'b1;
        end
    end

    // Busy until the array engine reports completion; a new start wins over done
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else if (go_any_op) begin
            busy_q <= 1'b1;
        end else if (op_done) begin
            busy_q <= 1'b0;
        end
    end

    // Suspend, performance, deep sleep and the two-frame soft reset
    always_ff @(posedge clk) begin
        if (srst || reset_go) begin
            susp_q <= 1'b0;
            perf_q <= 1'b0;
            sleep_q <= 1'b0;
            reset_armed_q <= 1'b0;
        end else if (aligned) begin
            reset_armed_q <= short_cmd && opcode_q == CMD_RESET_ARM;
            if (short_cmd && sleep_gate && opcode_q == CMD_SUSPEND) begin
                susp_q <= 1'b1;
            end
            if (short_cmd && sleep_gate && opcode_q == CMD_RESUME) begin
                susp_q <= 1'b0;
            end
            if (sleep_gate && opcode_q == CMD_HIGH_PERF && byte_cnt_q == LEN_ADDR_FRAME) begin
                perf_q <= 1'b1;
            end
            if (short_cmd && opcode_q == CMD_DEEP_SLEEP) begin
                sleep_q <= 1'b1;
            end
            if (opcode_q == CMD_WAKE) begin
                sleep_q <= 1'b0;
            end
        end else if (frame_end) begin
            reset_armed_q <= 1'b0;
        end
    end

    // ************************************************************
    // Array engine handshake and page data buffer
    // ************************************************************
    logic page_push;
    logic page_pushed_q;
    logic fifo_in_ready;

    assign page_push = byte_done && opcode_q == CMD_PAGE_WRITE && byte_cnt_q >= LEN_ADDR_FRAME
        && may_modify && !addr_shielded;

    // Start pulse with kind and address; abort tells the engine to drop buffered bytes
    always_ff @(posedge clk) begin
        if (srst) begin
            op_start <= 1'b0;
            op_abort <= 1'b0;
            op_kind <= OPK_NONE;
            op_addr <= 24'h000000;
            page_pushed_q <= 1'b0;
        end else begin
            op_start <= go_any_op;
            op_abort <= frame_end && page_pushed_q && !go_page;
            if (go_any_op) begin
                op_addr <= addr_q;
                op_kind <= go_status ? OPK_STATUS : go_page ? OPK_PAGE : go_sector ? OPK_SECTOR
                    : go_b32 ? OPK_BLOCK32 : go_b64 ? OPK_BLOCK64 : OPK_CHIP;
            end
            if (frame_start) begin
                page_pushed_q <= 1'b0;
            end else if (page_push) begin
                page_pushed_q <= 1'b1;
            end
        end
    end

    // Host cannot be stalled, so a full buffer drops the byte and flags it
    always_ff @(posedge clk) begin
        if (srst) begin
            prog_overflow <= 1'b0;
        end else if (page_push && !fifo_in_ready) begin
            prog_overflow <= 1'b1;
        end else if (frame_start) begin
            prog_overflow <= 1'b0;
        end
    end

    sfs_byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_page_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(page_push),
        .in_ready(fifo_in_ready),
        .in_data(rx_byte),
        .out_valid(prog_valid),
        .out_ready(prog_ready),
        .out_data(prog_data)
    );

    // ************************************************************
    // Status read output
    // ************************************************************
    logic tx_on_q;
    logic tx_hi_q;
    logic [2:0] tx_cnt_q;
    logic [7:0] tx_byte;
    assign tx_byte = tx_hi_q ? status_word[15:8] : status_word[7:0];
    assign so_oe = tx_on_q && !cs_s;

    // Live status repeats every byte until the host ends the frame
    always_ff @(posedge clk) begin
        if (srst || cs_s) begin
            tx_on_q <= 1'b0;
            tx_hi_q <= 1'b0;
            tx_cnt_q <= 3'h0;
            so <= 1'b0;
        end else if (byte_done && byte_cnt_q == 8'h00
            && (rx_byte == CMD_STATUS_RD_LO || rx_byte == CMD_STATUS_RD_HI)) begin
            tx_on_q <= 1'b1;
            tx_hi_q <= (rx_byte == CMD_STATUS_RD_HI);
        end else if (sclk_fall && tx_on_q) begin
            so <= tx_byte[3'h7 - tx_cnt_q];
            tx_cnt_q <= tx_cnt_q + 3'h1;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_busy_on_start: assert property (op_start |-> status_word[BIT_BUSY])
        else $error("busy flag not set at operation start");
    a_busy_clears: assert property (busy_q && op_done && !go_any_op |=> !status_word[BIT_BUSY])
        else $error("busy flag not cleared by done");
    a_latch_needed: assert property (op_start |-> $past(latch_q, 1) && !status_word[BIT_LATCH])
        else $error("operation started without latch or latch kept");
    a_chip_gate: assert property (op_start && op_kind == OPK_CHIP |-> $past(chip_ok, 1))
        else $error("chip erase with protect bits set");
    a_protect_freeze: assert property (!$past(srst) && $changed(status_word[8:2]) |-> $past(sr_write_ok, 1))
        else $error("protect bits changed without permitted status write");
    a_lock_sticky: assert property ($past(status_word[BIT_LOCK]) && !$past(srst) |-> status_word[BIT_LOCK])
        else $error("security lock bit fell");
    a_reserved_zero: assert property (status_word[12:11] == 2'h0)
        else $error("reserved bits not zero");
    a_byte_boundary: assert property (op_start |-> $past(bit_cnt_q, 1) == 3'h0 && $past(frame_end, 1))
        else $error("operation from unaligned frame");
    a_suspend_set: assert property (aligned && short_cmd && opcode_q == CMD_SUSPEND && !sleep_q && !reset_go
        |=> status_word[BIT_SUSP])
        else $error("suspend flag not set");
    a_partial_page: assert property (frame_end && bit_cnt_q != 3'h0 && latch_q |=> latch_q && !op_start)
        else $error("partial frame changed latch or started");

    c_status_read: cover property (so_oe ##1 sclk_fall);
    c_page_start: cover property (op_start && op_kind == OPK_PAGE);
    c_chip_erase: cover property (op_start && op_kind == OPK_CHIP);
    c_partial_drop: cover property (frame_end && bit_cnt_q != 3'h0 && opcode_q == CMD_PAGE_WRITE);
endmodule : sfs_flash_status

// ===== verification/sfs_host_model.sv
`timescale 1ns/1ns
// ********************************
// Host end of the serial link
// ********************************
module sfs_host_model (
    output logic cs_n,
    output logic sclk,
    output logic si,
    input logic so
);
    // Idle: deselected, clock parked low between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // Shift n bits MSB first; so is taken at each rising edge
    task automatic xbyte(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            si = b[7-i];
            #63 sclk = 1'b1;
            r = {r[6:0], so};
            #62 sclk = 1'b0;
        end
    endtask : xbyte
    task automatic open_frame();
        cs_n = 1'b0;
        #100;
    endtask : open_frame
    // si flips after release so a stale bit is never read as data
    task automatic close_frame();
        #60 cs_n = 1'b1;
        si = ~si;
        #200;
    endtask : close_frame
endmodule : sfs_host_model

// ===== verification/test_sfs_flash_status.sv
`timescale 1ns/1ns
// ********************************
// Status word and framing bench
// ********************************
module test_sfs_flash_status;
    import sfs_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wp_n = 1'b1, op_done = 1'b0, prog_ready = 1'b0;
    logic cs_n, sclk, si, so, so_oe, quad_mode, op_start, op_abort, prog_valid, prog_overflow;
    logic [15:0] status_word;
    logic [23:0] op_addr;
    logic [7:0] prog_data, r;
    sfs_op_t op_kind;
    int num_errors = 0, total_checks = 0, starts = 0, aborts = 0;
    logic so_pin;
    always #5 clk = ~clk;
    // Count accepted operations and dropped page frames
    always @(posedge clk) if (op_start) starts <= starts + 1;
    always @(posedge clk) if (op_abort) aborts <= aborts + 1;
    // Undriven line shows the inverse, so a missing output enable corrupts read data
    assign so_pin = so_oe ? so : ~so;
    sfs_host_model sfs_host_model_inst (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_pin));
    sfs_flash_status sfs_flash_status_inst (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
        .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .quad_mode(quad_mode),
        .status_word(status_word), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
        .op_abort(op_abort), .op_done(op_done), .prog_data(prog_data), .prog_valid(prog_valid),
        .prog_ready(prog_ready), .prog_overflow(prog_overflow));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic frame(input logic [7:0] q[$], input int tail);
        sfs_host_model_inst.open_frame();
        foreach (q[i]) sfs_host_model_inst.xbyte(q[i], 8, r);
        if (tail > 0) sfs_host_model_inst.xbyte(8'hA5, tail, r);
        sfs_host_model_inst.close_frame();
    endtask : frame
    // Engine completion pulse
    task automatic done();
        @(negedge clk) op_done = 1'b1;
        @(negedge clk) op_done = 1'b0;
        @(negedge clk);
        check(status_word[0], 1'b0);
    endtask : done
    // Latch set, then the frame; go says whether it must start
    task automatic op(input logic [7:0] q[$], input int tail, input logic go, input sfs_op_t k);
        int s;
        s = starts;
        frame('{CMD_LATCH_SET}, 0);
        frame(q, tail);
        check(starts - s, go);
        check(status_word[0], go);
        if (go) begin
            check(op_kind, k);
            check(status_word[1], 1'b0);
            done();
        end
    endtask : op
    task automatic sw(input logic [7:0] lo, input logic [7:0] hi, input logic go);
        op('{CMD_STATUS_WRITE, lo, hi}, 0, go, OPK_STATUS);
    endtask : sw
    task automatic rdchk(input logic [15:0] exp);
        logic [15:0] v;
        sfs_host_model_inst.open_frame();
        sfs_host_model_inst.xbyte(CMD_STATUS_RD_LO, 8, r);
        check(so_oe, 1'b1);
        sfs_host_model_inst.xbyte(8'h00, 8, v[7:0]);
        sfs_host_model_inst.close_frame();
        check(so_oe, 1'b0);
        sfs_host_model_inst.open_frame();
        sfs_host_model_inst.xbyte(CMD_STATUS_RD_HI, 8, r);
        sfs_host_model_inst.xbyte(8'h00, 8, v[15:8]);
        sfs_host_model_inst.close_frame();
        check(v, exp);
        check(status_word, exp);
    endtask : rdchk
    task automatic t_latch();
        check(status_word, 16'h0000);
        frame('{CMD_LATCH_SET}, 0);
        check(status_word[1], 1'b1);
        frame('{CMD_LATCH_CLR}, 0);
        check(status_word[1], 1'b0);
        frame('{CMD_LATCH_SET}, 1);
        check(status_word[1], 1'b0);
        frame('{CMD_STATUS_WRITE, 8'h1C}, 0);
        check(status_word, 16'h0000);
    endtask : t_latch
    // Status bits, chip erase gate, address protection
    task automatic t_protect();
        sw(8'h1F, 8'hF8, 1'b1);
        rdchk(16'h401C);
        op('{CMD_CHIP_WIPE_A}, 0, 1'b1, OPK_CHIP);
        op('{CMD_CHIP_WIPE_B}, 0, 1'b1, OPK_CHIP);
        sw(8'h1C, 8'h00, 1'b1);
        op('{CMD_CHIP_WIPE_A}, 0, 1'b0, OPK_NONE);
        sw(8'h04, 8'h00, 1'b1);
        op('{CMD_SECTOR_WIPE, 8'h07, 8'h00, 8'h00}, 0, 1'b0, OPK_NONE);
        op('{CMD_SECTOR_WIPE, 8'h00, 8'h10, 8'h00}, 4, 1'b0, OPK_NONE);
        op('{CMD_SECTOR_WIPE, 8'h00, 8'h10, 8'h00}, 0, 1'b1, OPK_SECTOR);
        check(op_addr, 24'h001000);
        op('{CMD_BLOCK32_WIPE, 8'h00, 8'h00, 8'h00}, 0, 1'b1, OPK_BLOCK32);
        op('{CMD_BLOCK64_WIPE, 8'h00, 8'h00, 8'h00}, 0, 1'b1, OPK_BLOCK64);
    endtask : t_protect
    // Buffer filled past full while stalled, then drained with stalls
    task automatic t_page();
        logic [7:0] q[$];
        int n;
        op('{CMD_PAGE_WRITE, 8'h00, 8'h02, 8'h00, 8'h11}, 3, 1'b0, OPK_NONE);
        check(status_word[1], 1'b1);
        check(aborts, 1);
        // Engine drops the byte buffered by the cut frame
        check(prog_valid, 1'b1);
        check(prog_data, 8'h11);
        @(negedge clk) prog_ready = 1'b1;
        @(negedge clk) prog_ready = 1'b0;
        check(prog_valid, 1'b0);
        op('{CMD_PAGE_WRITE, 8'h07, 8'h00, 8'h00, 8'h11}, 0, 1'b0, OPK_NONE);
        q = '{CMD_PAGE_WRITE, 8'h00, 8'h02, 8'h00};
        for (int i = 0; i < 17; i++) q.push_back(8'(8'h30 + i));
        frame('{CMD_LATCH_SET}, 0);
        frame(q, 0);
        check(op_kind, OPK_PAGE);
        check(prog_overflow, 1'b1);
        n = 0;
        for (int c = 0; c < 200 && n < 16; c++) begin
            // Judge the head before the edge that takes it
            @(negedge clk) prog_ready = c[0];
            if (prog_valid === 1'b1 && prog_ready === 1'b1) begin
                check(prog_data, 8'(8'h30 + n));
                n++;
            end
        end
        @(negedge clk) prog_ready = 1'b0;
        check(n, 16);
        check(prog_valid, 1'b0);
        done();
    endtask : t_page
    task automatic reset_dut();
        @(negedge clk) srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
    endtask : reset_dut
    // Select modes against the protect pin
    task automatic t_select();
        wp_n = 1'b0;
        sw(8'h80, 8'h00, 1'b1);
        sw(8'h84, 8'h00, 1'b0);
        wp_n = 1'b1;
        sw(8'h00, 8'h01, 1'b1);
        sw(8'h00, 8'h00, 1'b0);
        reset_dut();
        check(status_word, 16'h0000);
        sw(8'h80, 8'h01, 1'b1);
        sw(8'h00, 8'h00, 1'b0);
        reset_dut();
    endtask : t_select
    task automatic t_flags();
        sw(8'h00, 8'h06, 1'b1);
        check(quad_mode, 1'b1);
        frame('{CMD_SUSPEND}, 0);
        check(status_word[15], 1'b1);
        frame('{CMD_RESUME}, 0);
        check(status_word[15], 1'b0);
        frame('{CMD_SUSPEND}, 0);
        frame('{CMD_HIGH_PERF, 8'h00, 8'h00, 8'h00}, 0);
        check(status_word[13], 1'b1);
        // Deep sleep ignores the latch command until wake
        frame('{CMD_DEEP_SLEEP}, 0);
        frame('{CMD_LATCH_SET}, 0);
        check(status_word[1], 1'b0);
        frame('{CMD_WAKE}, 0);
        frame('{CMD_LATCH_SET}, 0);
        check(status_word[1], 1'b1);
        frame('{CMD_RESET_ARM}, 0);
        frame('{CMD_RESET_GO}, 0);
        check(status_word[15:13], 3'h0);
        check(status_word[1], 1'b0);
    endtask : t_flags
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        t_latch();
        t_protect();
        t_page();
        t_select();
        t_flags();
        tally_and_finish();
    end
    // Watchdog: the full run needs well under half this span
    initial begin
        #900000;
        num_errors++;
        tally_and_finish();
    end
endmodule : test_sfs_flash_status
